/* File: core/via_pkg.sv */
// constants for the vectored interrupt arbiter
package via_pkg;
   localparam int          VIA_NUM_SRC        = 19;
   localparam int          VIA_NUM_EXT        = 4;
   localparam int          VIA_NUM_INT        = 15;
   localparam int          VIA_NUM_SOURCES    = 20;
   localparam int          VIA_IDX_W          = 5;
   localparam int          VIA_VEC_W          = 16;
   // source index equals default priority, 0 wins
   localparam int          VIA_LOW_VOLTAGE_IRQ       = 0;
   localparam int          VIA_EXT_PIN_IRQ_0         = 1;
   localparam int          VIA_EXT_PIN_IRQ_3         = 4;
   localparam int          VIA_USB_STATUS0_IRQ       = 5;
   localparam int          VIA_USB_STATUS1_IRQ       = 6;
   localparam int          VIA_ASYNC_RX_ERROR_IRQ    = 7;
   localparam int          VIA_ASYNC_RX_DONE_IRQ     = 8;
   localparam int          VIA_ASYNC_TX_DONE_IRQ     = 9;
   localparam int          VIA_CLOCKED_SERIAL_IRQ    = 10;
   localparam int          VIA_TIMER_H_MATCH_IRQ     = 11;
   localparam int          VIA_USB_STATUS2_IRQ       = 12;
   localparam int          VIA_EVENT_TIMER_A_IRQ     = 13;
   localparam int          VIA_WIDE_TIMER_CH0_IRQ    = 14;
   localparam int          VIA_WIDE_TIMER_CH1_IRQ    = 15;
   localparam int          VIA_USB_RESUME_IRQ        = 16;
   localparam int          VIA_FLASH_SEQ_DONE_IRQ    = 17;
   localparam int          VIA_EVENT_TIMER_B_IRQ     = 18;
   // vector table
   localparam logic [15:0] VIA_VEC_RESET      = 16'h0000;
   localparam logic [15:0] VIA_VEC_FIRST      = 16'h0004;
   localparam logic [15:0] VIA_VEC_LAST_TIMER = 16'h002A;
   localparam logic [15:0] VIA_VEC_BREAK      = 16'h003E;
   localparam int          VIA_LVM_RESET_BIT  = 1;
   // register byte offsets
   localparam logic [7:0]  VIA_OFS_REQ        = 8'h00;
   localparam logic [7:0]  VIA_OFS_MASK       = 8'h04;
   localparam logic [7:0]  VIA_OFS_PRIO       = 8'h08;
   localparam logic [7:0]  VIA_OFS_LVM        = 8'h0C;
   localparam logic [7:0]  VIA_OFS_STATUS     = 8'h10;
   // values after reset
   localparam logic [18:0] VIA_RST_REQ        = 19'h00000;
   localparam logic [18:0] VIA_RST_MASK       = 19'h7FFFF;
   localparam logic [18:0] VIA_RST_PRIO       = 19'h7FFFF;
   localparam logic [7:0]  VIA_RST_LVM        = 8'h00;
endpackage

/* File: core/via_arbiter.sv */
// vectored interrupt arbiter with apb register access
`timescale 1ns/10ps
`default_nettype none
module via_arbiter
   import via_pkg::*;
(
   input  wire logic                 i_clock,
   input  wire logic                 i_resetn,
   input  wire logic                 i_clk_en,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic                 i_low_voltage_detect,
   input  wire logic [18:1]          i_periph_irq,
   input  wire logic                 i_software_break_instr,
   input  wire logic                 i_ext_reset,
   input  wire logic                 i_power_on_clear,
   input  wire logic                 i_watchdog_overflow_reset,
   input  wire logic                 i_int_enable,
   input  wire logic                 i_take,
   input  wire logic                 i_return,
   output logic                      o_int_req,
   output logic                      o_ack,
   output logic      [15:0]          o_vector,
   output logic                      o_standby_release,
   output logic                      o_reset_req
);

   ////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [VIA_IDX_W-1:0] via_first(input logic [18:0] v);
      logic [VIA_IDX_W-1:0] idx;
      idx = '0;
      for (int k = VIA_NUM_SRC - 1; k >= 0; k--)
      begin
         if (v[k])
         begin
            idx = VIA_IDX_W'(k);
         end
      end
      return idx;
   endfunction

   // table slot 0028 is skipped, so the last source jumps over it
   function automatic logic [15:0] via_vec(input logic [VIA_IDX_W-1:0] idx);
      logic [15:0] v;
      v = VIA_VEC_FIRST + {10'h000, idx, 1'b0};
      if (idx == VIA_IDX_W'(VIA_EVENT_TIMER_B_IRQ))
      begin
         v = VIA_VEC_LAST_TIMER;
      end
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // state

   logic [18:0]          req_reg;
   logic [18:0]          req_next;
   logic [18:0]          mask_reg;
   logic [18:0]          mask_next;
   logic [18:0]          prio_reg;
   logic [18:0]          prio_next;
   logic [7:0]           lvm_reg;
   logic [7:0]           lvm_next;
   logic                 isp_high_reg;
   logic                 isp_high_next;
   logic                 isp_low_reg;
   logic                 isp_low_next;
   logic                 brk_reg;
   logic                 brk_next;
   logic                 int_req_reg;
   logic                 ack_reg;
   logic [15:0]          vector_reg;
   logic [15:0]          vector_next;
   logic                 wake_reg;
   logic                 reset_req_reg;

   ////////////////////////////////////////////////////////////////////////
   // arbitration

   wire        lvm_reset_mode = lvm_reg[VIA_LVM_RESET_BIT];
   wire        lvd_irq        = i_low_voltage_detect & ~lvm_reset_mode;
   wire [18:0] src_set        = {i_periph_irq, lvd_irq};
   wire [18:0] pend_all       = req_reg & ~mask_reg;
   wire [18:0] pend_high      = pend_all & ~prio_reg;
   wire [18:0] pend_low       = pend_all & prio_reg;
   // a high group request may break into a low group service
   wire        high_ok        = ~isp_high_reg & (|pend_high);
   wire        low_ok         = ~isp_high_reg & ~isp_low_reg & (|pend_low);
   wire [18:0] pick_set       = high_ok ? pend_high : pend_low;
   wire        maskable_ok    = i_int_enable & (high_ok | low_ok);
   wire [4:0]  win_idx        = via_first(pick_set);
   wire [15:0] win_vec        = via_vec(win_idx);
   // break ignores enable and groups entirely
   wire        take_brk       = i_take & brk_reg;
   wire        take_mask      = i_take & ~brk_reg & maskable_ok;
   wire [18:0] ack_clr        = take_mask ? (19'h00001 << win_idx) : 19'h00000;
   wire        any_reset      = i_ext_reset | i_power_on_clear |
                                i_watchdog_overflow_reset |
                                (i_low_voltage_detect & lvm_reset_mode);

   ////////////////////////////////////////////////////////////////////////
   // apb decode

   wire        apb_wr   = psel & penable & pwrite;
   wire        hit_req  = (paddr == VIA_OFS_REQ);
   wire        hit_mask = (paddr == VIA_OFS_MASK);
   wire        hit_prio = (paddr == VIA_OFS_PRIO);
   wire        hit_lvm  = (paddr == VIA_OFS_LVM);
   wire        hit_stat = (paddr == VIA_OFS_STATUS);
   wire        hit_any  = hit_req | hit_mask | hit_prio | hit_lvm | hit_stat;
   wire [31:0] status_word = {13'h0000, vector_reg, brk_reg, isp_low_reg, isp_high_reg};

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit_any;
   assign prdata  = ~(psel & penable) ? 32'h00000000 :
                    hit_req  ? {13'h0000, req_reg}  :
                    hit_mask ? {13'h0000, mask_reg} :
                    hit_prio ? {13'h0000, prio_reg} :
                    hit_lvm  ? {24'h000000, lvm_reg} :
                    hit_stat ? status_word : 32'h00000000;

   ////////////////////////////////////////////////////////////////////////
   // next state

   // a source pulse in the clearing cycle still leaves the flag set
   assign req_next  = src_set |
                      ((apb_wr & hit_req) ? pwdata[18:0] : (req_reg & ~ack_clr));
   assign mask_next = (apb_wr & hit_mask) ? pwdata[18:0] : mask_reg;
   assign prio_next = (apb_wr & hit_prio) ? pwdata[18:0] : prio_reg;
   assign lvm_next  = (apb_wr & hit_lvm) ? pwdata[7:0] : lvm_reg;
   assign brk_next  = i_software_break_instr | (brk_reg & ~take_brk);

   // return releases the innermost level: high if set, else low
   assign isp_high_next = (take_mask & high_ok) |
                          (isp_high_reg & ~i_return);
   assign isp_low_next  = (take_mask & ~high_ok) |
                          (isp_low_reg & ~(i_return & ~isp_high_reg));

   assign vector_next = any_reset ? VIA_VEC_RESET :
                        take_brk  ? VIA_VEC_BREAK :
                        take_mask ? win_vec : vector_reg;

   ////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         req_reg       <= VIA_RST_REQ;
         mask_reg      <= VIA_RST_MASK;
         prio_reg      <= VIA_RST_PRIO;
         lvm_reg       <= VIA_RST_LVM;
         isp_high_reg  <= 1'b0;
         isp_low_reg   <= 1'b0;
         brk_reg       <= 1'b0;
      end
      else if (i_clk_en)
      begin
         req_reg       <= req_next;
         mask_reg      <= mask_next;
         prio_reg      <= prio_next;
         lvm_reg       <= lvm_next;
         isp_high_reg  <= isp_high_next;
         isp_low_reg   <= isp_low_next;
         brk_reg       <= brk_next;
      end
   end

   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         int_req_reg   <= 1'b0;
         ack_reg       <= 1'b0;
         vector_reg    <= VIA_VEC_RESET;
         wake_reg      <= 1'b0;
         reset_req_reg <= 1'b0;
      end
      else if (i_clk_en)
      begin
         int_req_reg   <= brk_next | (maskable_ok & ~take_mask);
         ack_reg       <= take_brk | take_mask;
         vector_reg    <= vector_next;
         wake_reg      <= |(req_next & ~mask_next);
         reset_req_reg <= any_reset;
      end
   end

   assign o_int_req         = int_req_reg;
   assign o_ack             = ack_reg;
   assign o_vector          = vector_reg;
   assign o_standby_release = wake_reg;
   assign o_reset_req       = reset_req_reg;

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking via_cb @(posedge i_clock);
   endclocking
   default disable iff (!i_resetn);

   ack_vec_match_a: assert property (
      i_clk_en && take_mask && !any_reset |=> o_ack && o_vector == $past(win_vec))
      else $error("acknowledge vector does not match winner");

   brk_vector_a: assert property (
      i_clk_en && i_take && brk_reg && !any_reset |=> o_ack && o_vector == 16'h003E)
      else $error("break vector wrong");

   reset_vector_a: assert property (
      i_clk_en && any_reset |=> o_reset_req && o_vector == 16'h0000)
      else $error("reset vector wrong");

   flag_clear_ack_a: assert property (
      i_clk_en && take_mask && !src_set[win_idx] && !apb_wr
      |=> !req_reg[$past(win_idx)])
      else $error("acknowledged flag not cleared");

   flag_set_src_a: assert property (
      i_clk_en && src_set[3] |=> req_reg[3])
      else $error("source request lost");

   lvd_gate_a: assert property (
      i_clk_en && lvm_reset_mode && !req_reg[0] && !apb_wr |=> !req_reg[0])
      else $error("low voltage interrupt in reset mode");

   lvd_reset_a: assert property (
      i_clk_en && i_low_voltage_detect && lvm_reset_mode |=> o_reset_req)
      else $error("low voltage reset missed");

   high_first_a: assert property (
      i_clk_en && take_mask && (|pend_high) && !isp_high_reg |-> !prio_reg[win_idx])
      else $error("low group chosen over high group");

   nest_block_a: assert property (
      i_clk_en && isp_low_reg && take_mask |-> !prio_reg[win_idx] ##1 isp_high_reg)
      else $error("low group nested over low group");

   order_a: assert property (
      take_mask && win_idx != 5'h00 |-> pick_set[win_idx - 5'h01] == 1'b0)
      else $error("default priority order broken");

   wake_a: assert property (
      i_clk_en && (|(req_reg & ~mask_reg)) ##1 i_clk_en && (|(req_reg & ~mask_reg))
      |-> o_standby_release)
      else $error("standby release missing");

   vec_last_a: assert property (
      take_mask && win_idx == 5'd18 |-> win_vec == 16'h002A)
      else $error("last source vector wrong");

   apb_err_a: assert property (
      psel && penable && !hit_any |-> pslverr && prdata == 32'h00000000)
      else $error("unmapped access not flagged");

   ////////////////////////////////////////////////////////////////////////
   // vector table checks
   // each one except vec_unused_a watches the registered vector one edge after a maskable take

   vec_low_volt_a: assert property (
      i_clk_en && take_mask && !any_reset && win_idx == 5'h00 |=> o_vector == 16'h0004)
      else $error("low voltage vector wrong");

   vec_ext_first_a: assert property (
      i_clk_en && take_mask && !any_reset && win_idx == 5'h01 |=> o_vector == 16'h0006)
      else $error("first pin vector wrong");

   vec_ext_last_a: assert property (
      i_clk_en && take_mask && !any_reset && win_idx == 5'h04 |=> o_vector == 16'h000C)
      else $error("last pin vector wrong");

   vec_usb_first_a: assert property (
      i_clk_en && take_mask && !any_reset && win_idx == 5'h05 |=> o_vector == 16'h000E)
      else $error("usb status 0 vector wrong");

   vec_usb_third_a: assert property (
      i_clk_en && take_mask && !any_reset && win_idx == 5'h0C |=> o_vector == 16'h001C)
      else $error("usb status 2 vector wrong");

   vec_rx_error_a: assert property (
      i_clk_en && take_mask && !any_reset && win_idx == 5'h07 |=> o_vector == 16'h0012)
      else $error("receive error vector wrong");

   vec_tx_done_a: assert property (
      i_clk_en && take_mask && !any_reset && win_idx == 5'h09 |=> o_vector == 16'h0016)
      else $error("transmit done vector wrong");

   vec_serial_a: assert property (
      i_clk_en && take_mask && !any_reset && win_idx == 5'h0A |=> o_vector == 16'h0018)
      else $error("clocked serial vector wrong");

   vec_timer_h_a: assert property (
      i_clk_en && take_mask && !any_reset && win_idx == 5'h0B |=> o_vector == 16'h001A)
      else $error("timer h vector wrong");

   vec_event_first_a: assert property (
      i_clk_en && take_mask && !any_reset && win_idx == 5'h0D |=> o_vector == 16'h001E)
      else $error("event timer a vector wrong");

   vec_wide_first_a: assert property (
      i_clk_en && take_mask && !any_reset && win_idx == 5'h0E |=> o_vector == 16'h0020)
      else $error("wide timer channel 0 vector wrong");

   vec_wide_second_a: assert property (
      i_clk_en && take_mask && !any_reset && win_idx == 5'h0F |=> o_vector == 16'h0022)
      else $error("wide timer channel 1 vector wrong");

   vec_resume_a: assert property (
      i_clk_en && take_mask && !any_reset && win_idx == 5'h10 |=> o_vector == 16'h0024)
      else $error("usb resume vector wrong");

   vec_flash_a: assert property (
      i_clk_en && take_mask && !any_reset && win_idx == 5'h11 |=> o_vector == 16'h0026)
      else $error("flash done vector wrong");

   vec_unused_a: assert property (
      take_mask |-> win_vec != 16'h0028 && win_vec < 16'h002C)
      else $error("unassigned vector used");

   ////////////////////////////////////////////////////////////////////////
   // break, acknowledge and clock enable checks

   brk_keeps_isp_a: assert property (
      i_clk_en && take_brk && !i_return |=> $stable(isp_high_reg) && $stable(isp_low_reg))
      else $error("break changed in-service state");

   brk_keeps_flags_a: assert property (
      i_clk_en && take_brk && !apb_wr |=> (req_reg & $past(req_reg)) == $past(req_reg))
      else $error("break consumed a maskable flag");

   brk_request_a: assert property (
      i_clk_en && i_software_break_instr |=> o_int_req)
      else $error("break request not shown");

   int_req_drop_a: assert property (
      i_clk_en && take_mask && !brk_next |=> !o_int_req)
      else $error("request stayed up after take");

   ack_pulse_a: assert property (
      i_clk_en && o_ack && !i_take |=> !o_ack)
      else $error("acknowledge longer than one cycle");

   state_freeze_a: assert property (
      !i_clk_en |=> $stable(req_reg) && $stable(o_vector))
      else $error("state moved with clock enable low");

endmodule
`default_nettype wire

/* File: bench/via_core_model.sv */
// processor core model: takes a pending interrupt while armed, then stays quiet for four cycles before the next
`timescale 1ns/10ps
`default_nettype none
module via_core_model
(
   input  wire logic       i_clock,
   input  wire logic       i_resetn,
   input  wire logic       i_arm,
   input  wire logic [1:0] i_delay,
   input  wire logic       i_int_req,
   output logic            o_take
);
   logic [1:0] wait_reg;
   logic [2:0] hold_reg;
   ////////////////////////////////////////////////////////////////////////////////
   // the quiet spell after a take keeps the still-high request from being taken twice
   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_take   <= 1'b0;
         wait_reg <= 2'b00;
         hold_reg <= 3'h0;
      end
      else
      begin
         o_take <= 1'b0;
         if (hold_reg != 3'h0)
            hold_reg <= hold_reg - 3'h1;
         else if (i_arm && i_int_req)
         begin
            // slow answers wait up to three extra cycles before taking
            if (wait_reg == i_delay)
            begin
               o_take   <= 1'b1;
               hold_reg <= 3'h4;
               wait_reg <= 2'b00;
            end
            else
               wait_reg <= wait_reg + 2'b01;
         end
         else
            wait_reg <= 2'b00;
      end
   end
endmodule
`default_nettype wire

/* File: bench/via_arbiter_bench.sv */
// self-checking testbench for the vectored interrupt arbiter
`timescale 1ns/10ps
`default_nettype none
module via_arbiter_bench;
   import via_pkg::*;
   logic        i_clock = 1'b0, i_resetn = 1'b0, i_clk_en = 1'b1, take;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000, prdata, rd;
   logic        i_low_voltage_detect = 1'b0, i_software_break_instr = 1'b0;
   logic [18:1] i_periph_irq = 18'h00000;
   logic        i_ext_reset = 1'b0, i_power_on_clear = 1'b0, i_watchdog_overflow_reset = 1'b0;
   logic        i_int_enable = 1'b1, i_return = 1'b0, arm = 1'b0;
   logic        o_int_req, o_ack, o_standby_release, o_reset_req;
   logic [15:0] o_vector;
   logic [1:0]  delay = 2'b00;
   logic [18:0] m, p;
   logic [15:0] exp_q[$];
   int          fail_count = 0, compares = 0, acks = 0;
   ////////////////////////////////////////////////////////////////////////////////
   always #10 i_clock = ~i_clock;
   via_arbiter via_arbiter_i (.i_clock, .i_resetn, .i_clk_en, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .i_low_voltage_detect, .i_periph_irq,
      .i_software_break_instr, .i_ext_reset, .i_power_on_clear, .i_watchdog_overflow_reset,
      .i_int_enable, .i_take(take), .i_return, .o_int_req, .o_ack, .o_vector,
      .o_standby_release, .o_reset_req);
   via_core_model via_core_model_i (.i_clock, .i_resetn, .i_arm(arm), .i_delay(delay),
      .i_int_req(o_int_req), .o_take(take));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stall();
      fail_count++;
      $display("[FAIL] %0t wait ran out", $time);
      report_and_stop();
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge i_clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clock);
      penable <= 1'b1;
      for (k = 0; k < 20; k++)
      begin
         @(posedge i_clock);
         if (pready === 1'b1) break;
      end
      if (k == 20) stall();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      check(rd, exp);
   endtask
   // one-cycle request pulses, so each source sets its flag exactly once while i_clk_en is high
   task automatic raise(input logic [18:0] mm, input logic b = 1'b0);
      @(posedge i_clock);
      i_periph_irq <= mm[18:1];
      i_low_voltage_detect <= mm[0];
      i_software_break_instr <= b;
      @(posedge i_clock);
      i_periph_irq <= 18'h00000;
      i_low_voltage_detect <= 1'b0;
      i_software_break_instr <= 1'b0;
   endtask
   task automatic serve(input logic [15:0] exp, input logic ret);
      int k, n0;
      n0 = acks;
      exp_q.push_back(exp);
      arm <= 1'b1;
      delay <= 2'($urandom_range(3));
      for (k = 0; k < 50; k++)
      begin
         @(posedge i_clock);
         if (acks != n0) break;
      end
      if (k == 50) stall();
      arm <= 1'b0;
      if (ret)
      begin
         @(posedge i_clock);
         i_return <= 1'b1;
         @(posedge i_clock);
         i_return <= 1'b0;
      end
      repeat (3) @(posedge i_clock);
   endtask
   function automatic logic [15:0] vec(input int n);
      return (n == VIA_EVENT_TIMER_B_IRQ) ? VIA_VEC_LAST_TIMER : VIA_VEC_FIRST + 16'(n << 1);
   endfunction
   function automatic int winner(input logic [18:0] mm, input logic [18:0] pp);
      logic [18:0] h;
      h = mm & ~pp;
      if (h == 19'h00000) h = mm;
      for (int i = 0; i < VIA_NUM_SRC; i++) if (h[i]) return i;
      return 0;
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   // every acknowledge consumes the oldest expected vector
   always @(posedge i_clock)
      if (o_ack === 1'b1)
      begin
         acks++;
         if (exp_q.size() != 0)
            check({16'h0000, o_vector}, {16'h0000, exp_q.pop_front()});
         else
            check({16'h0000, o_vector}, 32'hFFFFFFFF);
      end
   initial
   begin
      void'($urandom(42512));
      repeat (16) @(posedge i_clock);
      i_resetn <= 1'b1;
      rdchk(VIA_OFS_REQ, 32'h00000000);
      rdchk(VIA_OFS_MASK, 32'h0007FFFF);
      rdchk(VIA_OFS_PRIO, 32'h0007FFFF);
      rdchk(VIA_OFS_LVM, 32'h00000000);
      rdchk(8'h14, 32'h00000000);
      check({31'h0, err}, 32'h00000001);
      $display("test reset values done");
      apb(1'b1, VIA_OFS_MASK, 32'h00000000);
      raise(19'h7FFFF);
      for (int n = 0; n < VIA_NUM_SRC; n++)
         serve(vec(n), 1'b1);
      rdchk(VIA_OFS_REQ, 32'h00000000);
      $display("test default order done");
      apb(1'b1, VIA_OFS_PRIO, 32'h0003FFFF);
      raise(19'h40002);
      serve(VIA_VEC_LAST_TIMER, 1'b0);
      check({31'h0, o_int_req}, 32'h00000000);
      rdchk(VIA_OFS_STATUS, 32'h00000151);
      @(posedge i_clock);
      i_return <= 1'b1;
      @(posedge i_clock);
      i_return <= 1'b0;
      serve(vec(1), 1'b0);
      raise(19'h40000);
      serve(VIA_VEC_LAST_TIMER, 1'b1);
      @(posedge i_clock);
      i_return <= 1'b1;
      @(posedge i_clock);
      i_return <= 1'b0;
      $display("test groups and nesting done");
      apb(1'b1, VIA_OFS_MASK, 32'h0007FFFF);
      i_int_enable <= 1'b0;
      raise(19'h00080);
      repeat (2) @(posedge i_clock);
      check({31'h0, o_standby_release}, 32'h00000000);
      apb(1'b1, VIA_OFS_MASK, 32'h0007FF7F);
      repeat (2) @(posedge i_clock);
      check({31'h0, o_standby_release}, 32'h00000001);
      check({31'h0, o_int_req}, 32'h00000000);
      apb(1'b1, VIA_OFS_REQ, 32'h00000000);
      apb(1'b1, VIA_OFS_MASK, 32'h00000000);
      raise(19'h00000, 1'b1);
      serve(VIA_VEC_BREAK, 1'b0);
      i_int_enable <= 1'b1;
      raise(19'h00020, 1'b1);
      serve(VIA_VEC_BREAK, 1'b0);
      serve(vec(5), 1'b1);
      $display("test standby and break done");
      apb(1'b1, VIA_OFS_LVM, 32'(1 << VIA_LVM_RESET_BIT));
      for (int s = 0; s < 4; s++)
      begin
         @(posedge i_clock);
         {i_watchdog_overflow_reset, i_power_on_clear, i_ext_reset,
            i_low_voltage_detect} <= 4'(1 << s);
         @(posedge i_clock);
         {i_watchdog_overflow_reset, i_power_on_clear, i_ext_reset,
            i_low_voltage_detect} <= 4'h0;
         @(posedge i_clock);
         check({o_reset_req, 15'h0000, o_vector}, 32'h80000000);
      end
      rdchk(VIA_OFS_REQ, 32'h00000000);
      apb(1'b1, VIA_OFS_LVM, 32'h00000000);
      $display("test reset sources done");
      // with the enable low neither a source pulse nor a register write may land
      i_clk_en <= 1'b0;
      raise(19'h00004);
      apb(1'b1, VIA_OFS_MASK, 32'h0007FFFF);
      i_clk_en <= 1'b1;
      rdchk(VIA_OFS_REQ, 32'h00000000);
      rdchk(VIA_OFS_MASK, 32'h00000000);
      $display("test clock enable done");
      for (int r = 0; r < 24; r++)
      begin
         m = 19'($urandom);
         p = 19'($urandom);
         if (m == 19'h00000) m = 19'h00001;
         apb(1'b1, VIA_OFS_PRIO, {13'h0000, p});
         raise(m);
         serve(vec(winner(m, p)), 1'b1);
         apb(1'b1, VIA_OFS_REQ, 32'h00000000);
      end
      repeat (5) @(posedge i_clock);
      check(32'(exp_q.size()), 32'h00000000);
      $display("test random arbitration done");
      report_and_stop();
   end
endmodule
`default_nettype wire
